// ==== common/gate_ctrl_defines.svh ====
`ifndef GATE_CTRL_DEFINES_SVH
`define GATE_CTRL_DEFINES_SVH

// ****************************************
// clock and timing
// ****************************************
`define CLK_MHZ          200
`define MIN_PULSE_NS     1000
`define MIN_PULSE_CYC    ((`MIN_PULSE_NS * `CLK_MHZ + 999) / 1000)
`define DEAD_TIME_NS     2000
`define DEAD_TIME_CYC    ((`DEAD_TIME_NS * `CLK_MHZ + 999) / 1000)
`define CLEAR_TIME_NS    1650000
`define CLEAR_TIME_CYC   ((`CLEAR_TIME_NS * `CLK_MHZ + 999) / 1000)

// ****************************************
// register offsets
// ****************************************
`define REG_CTRL         8'h00
`define REG_PHASE        8'h04
`define REG_STATUS       8'h08
`define REG_IRQ_STAT     8'h0C
`define REG_IRQ_MASK     8'h10
`define REG_DEAD         8'h14

// ****************************************
// fields
// ****************************************
`define CTRL_RUN_BIT     0
`define CMD_OFF          2'h0
`define CMD_HIGH         2'h1
`define CMD_LOW          2'h2
`define IRQ_FAULT_BIT    0
`define IRQ_READY_BIT    1
`define IRQ_START_BIT    2
`define IRQ_W            3
`define DEAD_W           16

`endif

// ==== common/gate_ctrl_pkg.sv ====
package gate_ctrl_pkg;

	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic       psel;
		logic       penable;
		logic       pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} apb_req_s;

	typedef struct packed {
		logic high_side_in_u;
		logic high_side_in_v;
		logic high_side_in_w;
		logic low_side_in_u;
		logic low_side_in_v;
		logic low_side_in_w;
	} gate_pins_s;

	typedef logic [1:0] phase_cmd_t;

	typedef enum logic [1:0] {
		PH_OFF,
		PH_HIGH,
		PH_LOW
	} phase_state_e;

endpackage

// ==== core/phase_drive.sv ====
`timescale 1ns/1ps
`include "gate_ctrl_defines.svh"

module phase_drive
	import gate_ctrl_pkg::*;
#(
	parameter int MIN_CYC = `MIN_PULSE_CYC
) (
	// clock and reset
	input  wire logic              ref_clk,
	input  wire logic              nrst,
	// control
	input  wire phase_cmd_t        cmd,
	input  wire logic              allow_high,
	input  wire logic              kill,
	input  wire logic [`DEAD_W-1:0] gap,
	// pins and status
	output logic                   hi_r,
	output logic                   lo_r,
	output logic                   lo_done
);

	localparam logic [`DEAD_W-1:0] MIN_LAST = `DEAD_W'(MIN_CYC - 1);
	localparam logic [`DEAD_W-1:0] CNT_MAX  = '1;

	phase_state_e         state_r;
	logic [`DEAD_W-1:0]   cnt_r;
	logic [`DEAD_W-1:0]   off_len_r;
	logic [`DEAD_W-1:0]   on_len_r;
	logic                 want_high;
	logic                 want_low;

	assign want_high = (cmd == `CMD_HIGH);
	assign want_low  = (cmd == `CMD_LOW);
	assign lo_done   = lo_r && (cnt_r >= MIN_LAST);

	// ****************************************
	// per-phase sequencer
	// ****************************************
	// a change of direction always passes through off, so both inputs are
	// never high together and the gap is at least the dead time
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state_r <= PH_OFF;
			cnt_r   <= '0;
			hi_r    <= 1'b0;
			lo_r    <= 1'b0;
		end else begin
			case (state_r)
				PH_OFF: begin
					if (!kill && cnt_r >= gap && want_high && allow_high) begin // see R3 R5
						state_r <= PH_HIGH;
						hi_r    <= 1'b1; // see R1
						cnt_r   <= '0;
					end else if (!kill && cnt_r >= gap && want_low) begin // see R3
						state_r <= PH_LOW;
						lo_r    <= 1'b1;
						cnt_r   <= '0;
					end else if (cnt_r != CNT_MAX) begin
						cnt_r <= cnt_r + 1'b1;
					end
				end
				PH_HIGH: begin
					// kill may cut a pulse short: safety beats pulse width
					if (kill || (!want_high && cnt_r >= MIN_LAST)) begin // see R4 R8
						state_r <= PH_OFF;
						hi_r    <= 1'b0;
						cnt_r   <= '0;
					end else if (cnt_r != CNT_MAX) begin
						cnt_r <= cnt_r + 1'b1;
					end
				end
				PH_LOW: begin
					if (kill || (!want_low && cnt_r >= MIN_LAST)) begin // see R4 R8
						state_r <= PH_OFF;
						lo_r    <= 1'b0;
						cnt_r   <= '0;
					end else if (cnt_r != CNT_MAX) begin
						cnt_r <= cnt_r + 1'b1;
					end
				end
				default: begin
					state_r <= PH_OFF;
					hi_r    <= 1'b0;
					lo_r    <= 1'b0;
					cnt_r   <= '0;
				end
			endcase
		end
	end

	// ****************************************
	// checks
	// ****************************************
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			off_len_r <= '0;
			on_len_r  <= '0;
		end else begin
			off_len_r <= (hi_r || lo_r) ? '0 : ((off_len_r == CNT_MAX) ? off_len_r : off_len_r + 1'b1);
			on_len_r  <= !(hi_r || lo_r) ? '0 : ((on_len_r == CNT_MAX) ? on_len_r : on_len_r + 1'b1);
		end
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	no_overlap_a: assert property (!(hi_r && lo_r)) // see R3
		else $error("both inputs of a phase high");
	dead_gap_a: assert property ($rose(hi_r || lo_r) |-> off_len_r > $past(gap)) // see R3
		else $error("dead time too short");
	min_width_a: assert property ($fell(hi_r || lo_r) && !$past(kill) |-> on_len_r >= MIN_CYC) // see R4
		else $error("on pulse narrower than minimum");
	kill_off_a: assert property (kill |=> !hi_r && !lo_r) // see R8
		else $error("phase driven while shut down");
	low_first_a: assert property ($rose(hi_r) |-> $past(allow_high)) // see R5
		else $error("high side before start");
	high_pulse_c: cover property ($rose(hi_r) ##[1:1000] $fell(hi_r));

endmodule

// ==== core/gate_ctrl.sv ====
`timescale 1ns/1ps
`include "gate_ctrl_defines.svh"

// Notes on behaviour
// R1: every phase input is active high; high turns its transistor on
// R2: the module itself blocks simultaneous high and low drive of one phase
// R3: both inputs of a phase stay low for the dead time before either rises
// R4: on and off pulses shorter than one microsecond may be ignored; never emit them; here a kill still ends an on pulse at once
// R5: after power-up the first drive must be a low-side input
// R6: the module pulls its open-drain fault line low while a fault exists
// R7: fault releases itself; restart after clear time needs a new low-side input
// R8: on a seen fault all phase inputs are driven inactive at once
// R9: overcurrent sense above reference triggers overcurrent protection
// R10: enable high runs the gate drivers, enable low shuts them down
// R11: enable may be tied to the fault line, so fault also shuts down
// R12: high supply undervoltage disables only that phase
// R13: low supply undervoltage is a protection event
// R14: built-in timing variant clears faults after 2 ms unless set shorter; the clear wait here is 1.65 ms
// R15: overcurrent forces all gates off and asserts fault
// R16: low supply undervoltage holds fault low; high supply one is not shown
// R17: both inputs of a phase high drives neither gate
// R18: fault clear time is a parameter counted from the end of the fault
// R19: any shutdown source overrides all inputs until it is released
module gate_ctrl
	import gate_ctrl_pkg::*;
#(
	parameter int CLEAR_CYC = `CLEAR_TIME_CYC,
	parameter int MIN_CYC   = `MIN_PULSE_CYC
) (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	// register bus
	input  wire apb_req_s    apb_req,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// module pins
	output gate_pins_s       gate_pins,
	output logic             gate_enable,
	input  wire logic        fault_n,
	// interrupt
	output logic             irq
);

	localparam int CW = $clog2(CLEAR_CYC + 1);
	localparam logic [`DEAD_W-1:0] MIN_W = `DEAD_W'(MIN_CYC);

	// ****************************************
	// declarations
	// ****************************************
	logic                 run_r;
	logic [5:0]           phase_cmd_r;
	logic [`DEAD_W-1:0]   dead_r;
	logic [`IRQ_W-1:0]    irq_stat_r;
	logic [`IRQ_W-1:0]    irq_mask_r;
	logic [`IRQ_W-1:0]    irq_evt;
	logic [31:0]          prdata_r;
	logic                 irq_r;
	logic                 fault_meta_r;
	logic                 fault_sync_r;
	logic                 fault_d_r;
	logic                 fault_s;
	logic [CW-1:0]        clear_cnt_r;
	logic                 clear_busy;
	logic                 started_r;
	logic                 gate_enable_r;
	logic                 kill;
	logic [`DEAD_W-1:0]   gap;
	logic [2:0]           hi_v;
	logic [2:0]           lo_v;
	logic [2:0]           lo_done_v;
	logic                 setup;
	logic                 wr;

	function automatic logic reg_known(input logic [7:0] a);
		reg_known = (a == `REG_CTRL) || (a == `REG_PHASE) || (a == `REG_STATUS) ||
			(a == `REG_IRQ_STAT) || (a == `REG_IRQ_MASK) || (a == `REG_DEAD);
	endfunction

	function automatic logic [`DEAD_W-1:0] max_gap(input logic [`DEAD_W-1:0] a,
		input logic [`DEAD_W-1:0] b);
		max_gap = (a > b) ? a : b;
	endfunction

	// ****************************************
	// fault line synchroniser
	// ****************************************
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			fault_meta_r <= 1'b1;
			fault_sync_r <= 1'b1;
			fault_d_r    <= 1'b0;
		end else begin
			fault_meta_r <= fault_n;
			fault_sync_r <= fault_meta_r;
			fault_d_r    <= fault_s;
		end
	end

	assign fault_s = !fault_sync_r; // see R6

	// ****************************************
	// fault clear wait
	// ****************************************
	// the module may restart on its own after its clear time; holding the
	// inputs off for the same time keeps that restart under our control
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			clear_cnt_r <= '0;
		end else if (fault_s) begin
			clear_cnt_r <= CW'(CLEAR_CYC); // see R18 R7
		end else if (clear_cnt_r != '0) begin
			clear_cnt_r <= clear_cnt_r - 1'b1;
		end
	end

	assign clear_busy = (clear_cnt_r != '0);
	assign kill       = !run_r || fault_s || clear_busy; // see R8 R19

	// ****************************************
	// start sequence and enable
	// ****************************************
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			started_r <= 1'b0;
		end else if (kill) begin
			started_r <= 1'b0; // see R5 R7
		end else if (|lo_done_v) begin
			started_r <= 1'b1; // see R5
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			gate_enable_r <= 1'b0;
		end else begin
			gate_enable_r <= !kill; // see R10 R11
		end
	end

	assign gate_enable = gate_enable_r;

	// ****************************************
	// phase sequencers
	// ****************************************
	assign gap = max_gap(dead_r, MIN_W); // see R3 R4

	for (genvar p = 0; p < 3; p++) begin : g_phase
		phase_drive #(
			.MIN_CYC    (MIN_CYC)
		) u_phase (
			.ref_clk    (ref_clk),
			.nrst       (nrst),
			.cmd        (phase_cmd_r[2*p +: 2]),
			.allow_high (started_r),
			.kill       (kill),
			.gap        (gap),
			.hi_r       (hi_v[p]),
			.lo_r       (lo_v[p]),
			.lo_done    (lo_done_v[p])
		);
	end

	assign gate_pins.high_side_in_u = hi_v[0];
	assign gate_pins.high_side_in_v = hi_v[1];
	assign gate_pins.high_side_in_w = hi_v[2];
	assign gate_pins.low_side_in_u  = lo_v[0];
	assign gate_pins.low_side_in_v  = lo_v[1];
	assign gate_pins.low_side_in_w  = lo_v[2];

	// ****************************************
	// register bus
	// ****************************************
	// zero wait state: read data is captured in the setup cycle
	assign setup   = apb_req.psel && !apb_req.penable;
	assign wr      = apb_req.psel && apb_req.penable && apb_req.pwrite &&
		reg_known(apb_req.paddr);
	assign pready  = 1'b1;
	assign pslverr = apb_req.psel && apb_req.penable && !reg_known(apb_req.paddr);
	assign prdata  = prdata_r;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			run_r       <= 1'b0;
			phase_cmd_r <= '0;
			dead_r      <= `DEAD_W'(`DEAD_TIME_CYC);
			irq_mask_r  <= '0;
		end else if (wr) begin
			if (apb_req.paddr == `REG_CTRL) begin
				run_r <= apb_req.pwdata[`CTRL_RUN_BIT];
			end else if (apb_req.paddr == `REG_PHASE) begin
				phase_cmd_r <= apb_req.pwdata[5:0];
			end else if (apb_req.paddr == `REG_IRQ_MASK) begin
				irq_mask_r <= apb_req.pwdata[`IRQ_W-1:0];
			end else if (apb_req.paddr == `REG_DEAD) begin
				dead_r <= apb_req.pwdata[`DEAD_W-1:0];
			end
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			prdata_r <= '0;
		end else if (setup) begin
			if (apb_req.paddr == `REG_CTRL) begin
				prdata_r <= {31'h0, run_r};
			end else if (apb_req.paddr == `REG_PHASE) begin
				prdata_r <= {26'h0, phase_cmd_r};
			end else if (apb_req.paddr == `REG_STATUS) begin
				prdata_r <= {22'h0, gate_enable_r, lo_v, hi_v, clear_busy, started_r,
					fault_s};
			end else if (apb_req.paddr == `REG_IRQ_STAT) begin
				prdata_r <= {29'h0, irq_stat_r};
			end else if (apb_req.paddr == `REG_IRQ_MASK) begin
				prdata_r <= {29'h0, irq_mask_r};
			end else if (apb_req.paddr == `REG_DEAD) begin
				prdata_r <= {16'h0, dead_r};
			end else begin
				prdata_r <= '0;
			end
		end
	end

	// ****************************************
	// interrupts
	// ****************************************
	always_comb begin
		irq_evt = '0;
		irq_evt[`IRQ_FAULT_BIT] = fault_s && !fault_d_r;
		irq_evt[`IRQ_READY_BIT] = (clear_cnt_r == CW'(1)) && !fault_s;
		irq_evt[`IRQ_START_BIT] = !started_r && !kill && (|lo_done_v);
	end

	// a new event wins over a write-one-to-clear in the same cycle
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			irq_stat_r <= '0;
		end else if (wr && apb_req.paddr == `REG_IRQ_STAT) begin
			irq_stat_r <= (irq_stat_r & ~apb_req.pwdata[`IRQ_W-1:0]) | irq_evt;
		end else begin
			irq_stat_r <= irq_stat_r | irq_evt;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= |(irq_stat_r & irq_mask_r);
		end
	end

	assign irq = irq_r;

	// ****************************************
	// checks
	// ****************************************
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	pins_off_fault_a: assert property (fault_s |=> gate_pins == '0) // see R8
		else $error("phase inputs not cleared on fault");
	enable_fault_a: assert property (fault_s |=> !gate_enable) // see R11
		else $error("enable high during fault");
	clear_wait_a: assert property ($fell(fault_s) |-> clear_busy) // see R7
		else $error("clear wait not started at fault release");
	restart_low_a: assert property (fault_s |=> !started_r) // see R5
		else $error("start state kept over a fault");
	fault_irq_a: assert property ($rose(fault_s) |=> irq_stat_r[`IRQ_FAULT_BIT]) // see R8
		else $error("fault event not recorded");
	fault_seen_c: cover property ($rose(fault_s) ##[1:20] gate_pins == '0);
	started_c: cover property ($rose(started_r));
	irq_c: cover property ($rose(irq));

endmodule

// ==== verification/power_stage_model.sv ====
`timescale 1ns/1ps

// ****************************************
// power stage: input logic and protection
// ****************************************
module power_stage_model
	import gate_ctrl_pkg::*;
#(
	parameter int CLEAR_CYC = 40
) (
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       nrst,
	// control pins
	input  wire gate_pins_s pins,
	input  wire logic       enable,
	// sense inputs
	input  wire logic       overcurrent_sense,
	input  wire logic       low_uv,
	input  wire logic [2:0] high_uv,
	// outputs
	output logic            fault_drive,
	output logic [2:0]      gate_hi,
	output logic [2:0]      gate_lo
);
	logic [2:0] hi;
	logic [2:0] lo;
	logic       prot;
	logic       shut;
	logic       fault_r;
	logic       run_r;
	int         clr_r;

	assign hi = {pins.high_side_in_w, pins.high_side_in_v, pins.high_side_in_u};
	assign lo = {pins.low_side_in_w, pins.low_side_in_v, pins.low_side_in_u};
	// high supply undervoltage is left out of the fault line on purpose
	assign prot = overcurrent_sense | low_uv;
	assign fault_drive = prot | fault_r;
	assign shut = fault_drive | !enable;

	// clear time is counted from the end of the last protection cycle
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			fault_r <= 1'b0;
			clr_r <= 0;
		end else if (prot) begin
			fault_r <= 1'b1;
			clr_r <= 0;
		end else if (fault_r) begin
			clr_r <= clr_r + 1;
			fault_r <= (clr_r < CLEAR_CYC - 1);
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			run_r <= 1'b0;
		end else if (fault_drive) begin
			run_r <= 1'b0;
		end else if (|lo) begin
			run_r <= 1'b1;
		end
	end

	assign gate_hi = hi & ~lo & ~high_uv & {3{run_r & !shut}};
	assign gate_lo = lo & ~hi & ~high_uv & {3{!shut}};
endmodule

// ==== verification/three_phase_gate_protect_bench.sv ====
`timescale 1ns/1ps
`include "gate_ctrl_defines.svh"

module three_phase_gate_protect_bench
	import gate_ctrl_pkg::*;
;
	localparam int GAP = 30;
	localparam int MIN = 20;
	logic        ref_clk, nrst, pready, pslverr, gate_enable, irq;
	logic        fault_drive, oc, luv, err;
	logic [31:0] prdata, q;
	logic [2:0]  huv, ghi, glo;
	logic [5:0]  pp;
	apb_req_s    apb_req;
	gate_pins_s  gate_pins;
	int          error_cnt, n_tests;
	int          on_c[6];
	int          off_c[3];
	wire         fault_n = fault_drive ? 1'b0 : 1'b1;

	gate_ctrl #(.CLEAR_CYC(50), .MIN_CYC(MIN)) uut (
		.ref_clk(ref_clk), .nrst(nrst), .apb_req(apb_req), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .gate_pins(gate_pins),
		.gate_enable(gate_enable), .fault_n(fault_n), .irq(irq));
	power_stage_model #(.CLEAR_CYC(40)) stage (
		.ref_clk(ref_clk), .nrst(nrst), .pins(gate_pins), .enable(gate_enable),
		.overcurrent_sense(oc), .low_uv(luv), .high_uv(huv),
		.fault_drive(fault_drive), .gate_hi(ghi), .gate_lo(glo));

	always #2.5 ref_clk = ~ref_clk;

	// ****************************************
	// tasks
	// ****************************************
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic complete_run;
		if (error_cnt == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// one apb transfer; a later call starts at a later edge, so no double drive
	// waits for pready as long as it takes; only the watchdog ends a hung transfer
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		apb_req <= '{1'b1, 1'b0, wr, a, d};
		@(posedge ref_clk);
		apb_req.penable <= 1'b1;
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		apb_req <= '0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		check(q, e);
	endtask

	task automatic poll(input logic [7:0] a, input int b);
		int n;
		n = 0;
		do begin
			bus(1'b0, a, 32'h0);
			n++;
		end while (q[b] !== 1'b1 && n < 200);
		check(q[b], 1);
	endtask

	task automatic idle(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	task automatic wait_pins(input gate_pins_s e);
		int n;
		n = 0;
		while (gate_pins !== e && n < 300) begin
			@(negedge ref_clk);
			n++;
		end
		check(32'(gate_pins), 32'(e));
	endtask

	// ****************************************
	// pin monitor: overlap, dead time, pulse width
	// ****************************************
	always @(posedge ref_clk) begin
		for (int k = 0; k < 6; k++) begin
			if (pp[k] && !gate_pins[k] && gate_enable) check(32'(on_c[k] >= MIN), 1);
			on_c[k] = gate_pins[k] ? on_c[k] + 1 : 0;
		end
		for (int p = 0; p < 3; p++) begin
			if (gate_pins[5-p] & gate_pins[2-p]) check(32'(gate_pins), 0);
			if ((gate_pins[5-p] & !pp[5-p]) | (gate_pins[2-p] & !pp[2-p])) check(32'(off_c[p] > GAP), 1);
			off_c[p] = (gate_pins[5-p] | gate_pins[2-p]) ? 0 : off_c[p] + 1;
		end
		pp = gate_pins;
	end

	initial begin
		repeat (20000) @(posedge ref_clk);
		error_cnt++;
		complete_run;
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		ref_clk = 1'b0;
		nrst = 1'b0;
		apb_req = '0;
		{oc, luv, huv, pp} = '0;
		error_cnt = 0;
		n_tests = 0;
		repeat (6) @(posedge ref_clk);
		nrst <= 1'b1;
		idle(2);
		check({gate_pins, gate_enable, irq}, 0);
		rd(`REG_DEAD, 32'h190);
		rd(`REG_IRQ_MASK, 32'h0);
		wr(`REG_STATUS, 32'hFFFF);
		rd(`REG_STATUS, 32'h0);
		bus(1'b0, 8'h18, 32'h0);
		check(err, 1);
		check(q, 32'h0);
		wr(`REG_DEAD, GAP);
		wr(`REG_IRQ_MASK, 32'h7);
		wr(`REG_CTRL, 32'h1);
		idle(2);
		check(gate_enable, 1);
		wr(`REG_PHASE, 32'h1);
		idle(80);
		check(32'(gate_pins), 0);
		wr(`REG_PHASE, 32'h2);
		wait_pins(6'h04);
		poll(`REG_STATUS, 1);
		idle(2);
		check(irq, 1);
		rd(`REG_IRQ_STAT, 32'h4);
		wr(`REG_IRQ_STAT, 32'h4);
		idle(2);
		check(irq, 0);
		wr(`REG_PHASE, 32'h29);
		wait_pins(6'h23);
		rd(`REG_STATUS, 32'h38A);
		wr(`REG_PHASE, 32'h2A);
		wait_pins(6'h07);
		@(posedge ref_clk) huv <= 3'h2;
		idle(20);
		check(fault_n, 1);
		check(glo, 3'h5);
		@(posedge ref_clk) huv <= 3'h0;
		@(posedge ref_clk) oc <= 1'b1;
		idle(5);
		check({gate_pins, gate_enable}, 0);
		idle(1);
		check(irq, 1);
		wr(`REG_PHASE, 32'h15);
		idle(20);
		check(32'(gate_pins), 0);
		wr(`REG_IRQ_STAT, 32'h7);
		idle(2);
		check(irq, 0);
		@(posedge ref_clk) oc <= 1'b0;
		poll(`REG_IRQ_STAT, 1);
		wr(`REG_CTRL, 32'h1);
		idle(60);
		check(32'(gate_pins), 0);
		wr(`REG_PHASE, 32'h2A);
		wait_pins(6'h07);
		wr(`REG_IRQ_MASK, 32'h0);
		wr(`REG_IRQ_STAT, 32'h7);
		@(posedge ref_clk) luv <= 1'b1;
		idle(40);
		check(fault_n, 0);
		check(32'(gate_pins), 0);
		check(irq, 0);
		bus(1'b0, `REG_IRQ_STAT, 32'h0);
		check(q[0], 1);
		@(posedge ref_clk) luv <= 1'b0;
		wr(`REG_CTRL, 32'h0);
		idle(3);
		check({gate_pins, gate_enable}, 0);
		complete_run;
	end
endmodule
